// ---- design/dap_defs.vh ----
`ifndef DAP_DEFS_VH
`define DAP_DEFS_VH

// ----------------------------------------
// Procedure identifiers
// ----------------------------------------
`define DAP_ID_CONVERT 8'h16
`define DAP_ID_COND_FILL 8'h2A
`define DAP_ID_LINK_OFF 8'h2C
`define DAP_ID_LINK_ON 8'h2D
`define DAP_ID_AIN_COPY 8'h2E
`define DAP_ID_QRESET 8'h3C
`define DAP_ID_IQ_COMP 8'h3F

// ----------------------------------------
// Conversion and FIFO prefill
// ----------------------------------------
`define DAP_CONV_LEN 8'h72
`define DAP_FILL_IN 8'h01
`define DAP_FILL_OUT 8'h94
`define DAP_FILL_VAL 16'hFFFD

// ----------------------------------------
// Offset measurement
// ----------------------------------------
`define DAP_MEAS_LOG2 6
`define DAP_MEAS_LAST 8'h3F

// ----------------------------------------
// Timing
// ----------------------------------------
`define DAP_CLK_NS 100
`define DAP_STEP_NS 100000
// 100 us step at the 100 ns clock, sized for the 16-bit step timer
`define DAP_STEP_CYC 16'h03E8

// ----------------------------------------
// Error message codes (value arbitrary)
// ----------------------------------------
`define DAP_ERR_AIN_TIMEOUT 8'h01

`endif

// ---- design/dap_cmd.v ----
// Operation
// RQ1 - Convert 114 soft decisions from source buffer into 114 hard bits in destination.
// RQ2 - Queued reset acts only when dequeued, never on arrival.
// RQ3 - Queued reset kind has the same meaning as the immediate reset kind.
// RQ4 - Conditional command skips following procedures unless audio input fill reaches threshold.
// RQ5 - Link-off command masks voice serial link interrupts.
// RQ6 - Voice link traffic is possible only after link-on command executed.
// RQ7 - After any reset voice link interrupts stay disabled until link-on.
// RQ8 - Link-on prefills audio input with 1 and output with 148 words 0xFFFD.
// RQ9 - Controller issues link-on before the audio frame lock procedure.
// RQ10 - Offset command measures I/Q offsets and loads them for baseband reads.
// RQ11 - Audio input copy moves requested word count into selected memory buffer.
// RQ12 - Audio input copy waits for enough words, limit in 100 us steps.
// RQ13 - Audio input copy timeout sends an unsolicited error message.
// RQ14 - Baseband reads subtract loaded I and Q offsets from each sample.
// RQ15 - Messages are taken one at a time, in order, each finished first.
`timescale 1ns/1ps
`include "dap_defs.vh"

module dap_cmd (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Procedure message queue
  input wire msg_valid,
  input wire [7:0] msg_id,
  input wire [15:0] msg_p0,
  input wire [15:0] msg_p1,
  input wire [15:0] msg_p2,
  output reg msg_ready_q,
  // Unsolicited error message
  output reg err_valid_q,
  output reg [7:0] err_code_q,
  // Queued reset request
  output reg reset_req_q,
  output reg [7:0] reset_kind_q,
  // Voice serial link
  output reg vlink_irq_en_q,
  // Data memory, read data one cycle after the read strobe
  output reg [15:0] mem_addr_q,
  output reg mem_rd_q,
  output reg mem_wr_q,
  output reg [15:0] mem_wdata_q,
  input wire [15:0] mem_rdata,
  // Audio FIFOs
  input wire [8:0] ain_count,
  input wire [15:0] ain_data,
  output reg ain_pop_q,
  output reg afifo_flush_q,
  output reg ain_push_q,
  output reg aout_push_q,
  output reg [15:0] afifo_wdata_q,
  // Baseband samples
  input wire iq_valid,
  input wire [15:0] i_in,
  input wire [15:0] q_in,
  output reg iq_out_valid_q,
  output reg [15:0] i_out_q,
  output reg [15:0] q_out_q,
  output reg [15:0] i_offset_q,
  output reg [15:0] q_offset_q
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_CONV = 5'h02;
  localparam [4:0] S_FILL = 5'h04;
  localparam [4:0] S_MEAS = 5'h08;
  localparam [4:0] S_COPY = 5'h10;
  localparam [15:0] STEP_CYC = `DAP_STEP_CYC;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Buffer selector to base address, 256 words per buffer
  function [15:0] buf_base;
    input [15:0] sel;
    begin
      buf_base = {sel[7:0], 8'h00};
    end
  endfunction

  function [21:0] sext22;
    input [15:0] v;
    begin
      sext22 = {{6{v[15]}}, v};
    end
  endfunction

  reg [4:0] state_q;
  reg [1:0] phase_q;
  reg [7:0] idx_q;
  reg [15:0] src_q;
  reg [15:0] dst_q;
  reg [15:0] words_q;
  reg [15:0] limit_q;
  reg [15:0] tick_q;
  reg [15:0] steps_q;
  reg started_q;
  reg [15:0] skip_q;
  reg [21:0] acc_i_q;
  reg [21:0] acc_q_q;

  wire take = msg_valid & msg_ready_q;
  wire [15:0] ain_cnt16 = {7'h00, ain_count};
  wire [21:0] sum_i = acc_i_q + sext22(i_in);
  wire [21:0] sum_q = acc_q_q + sext22(q_in);

  // ----------------------------------------
  // Offset-compensated baseband samples
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      iq_out_valid_q <= 1'b0;
      i_out_q <= 16'h0000;
      q_out_q <= 16'h0000;
    end else begin
      iq_out_valid_q <= iq_valid;
      i_out_q <= i_in - i_offset_q; // RQ14
      q_out_q <= q_in - q_offset_q; // RQ14
    end
  end

  // ----------------------------------------
  // Procedure sequencer
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      state_q <= S_IDLE;
      msg_ready_q <= 1'b1;
      err_valid_q <= 1'b0;
      err_code_q <= 8'h00;
      reset_req_q <= 1'b0;
      reset_kind_q <= 8'h00;
      vlink_irq_en_q <= 1'b0; // RQ7
      mem_addr_q <= 16'h0000;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_wdata_q <= 16'h0000;
      ain_pop_q <= 1'b0;
      afifo_flush_q <= 1'b0;
      ain_push_q <= 1'b0;
      aout_push_q <= 1'b0;
      afifo_wdata_q <= 16'h0000;
      i_offset_q <= 16'h0000;
      q_offset_q <= 16'h0000;
      phase_q <= 2'h0;
      idx_q <= 8'h00;
      src_q <= 16'h0000;
      dst_q <= 16'h0000;
      words_q <= 16'h0000;
      limit_q <= 16'h0000;
      tick_q <= 16'h0000;
      steps_q <= 16'h0000;
      started_q <= 1'b0;
      skip_q <= 16'h0000;
      acc_i_q <= 22'h000000;
      acc_q_q <= 22'h000000;
    end else begin
      err_valid_q <= 1'b0;
      reset_req_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      ain_pop_q <= 1'b0;
      afifo_flush_q <= 1'b0;
      ain_push_q <= 1'b0;
      aout_push_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          phase_q <= 2'h0;
          idx_q <= 8'h00;
          tick_q <= 16'h0000;
          steps_q <= 16'h0000;
          started_q <= 1'b0;
          acc_i_q <= 22'h000000;
          acc_q_q <= 22'h000000;
          if (take && skip_q != 16'h0000) begin
            skip_q <= skip_q - 16'h0001; // RQ4
          end else if (take) begin
            case (msg_id) // RQ15
              `DAP_ID_CONVERT: begin
                src_q <= buf_base(msg_p0); // RQ1
                dst_q <= buf_base(msg_p1);
                msg_ready_q <= 1'b0;
                state_q <= S_CONV;
              end
              `DAP_ID_QRESET: begin
                // Acts here, in queue order, with the kind passed through unchanged
                reset_req_q <= 1'b1; // RQ2
                reset_kind_q <= msg_p0[7:0]; // RQ3
                vlink_irq_en_q <= 1'b0; // RQ7
              end
              `DAP_ID_COND_FILL: begin
                if (ain_cnt16 < msg_p0) begin
                  skip_q <= msg_p1; // RQ4
                end
              end
              `DAP_ID_LINK_OFF: begin
                vlink_irq_en_q <= 1'b0; // RQ5
              end
              `DAP_ID_LINK_ON: begin
                vlink_irq_en_q <= 1'b1; // RQ6
                msg_ready_q <= 1'b0;
                state_q <= S_FILL;
              end
              `DAP_ID_IQ_COMP: begin
                msg_ready_q <= 1'b0;
                state_q <= S_MEAS;
              end
              `DAP_ID_AIN_COPY: begin
                dst_q <= buf_base(msg_p0); // RQ11
                words_q <= msg_p1;
                limit_q <= msg_p2;
                msg_ready_q <= 1'b0;
                state_q <= S_COPY;
              end
              default: begin
                // Other procedures belong to other handlers
              end
            endcase
          end
        end
        S_CONV: begin
          // Read, wait one cycle for data, then write the sign as the hard bit
          case (phase_q)
            2'h0: begin
              mem_rd_q <= 1'b1;
              mem_addr_q <= src_q + {8'h00, idx_q};
              phase_q <= 2'h1;
            end
            2'h1: begin
              phase_q <= 2'h2;
            end
            default: begin
              mem_wr_q <= 1'b1; // RQ1
              mem_addr_q <= dst_q + {8'h00, idx_q};
              mem_wdata_q <= {15'h0000, mem_rdata[15]};
              phase_q <= 2'h0;
              idx_q <= idx_q + 8'h01;
              if (idx_q == `DAP_CONV_LEN - 8'h01) begin
                msg_ready_q <= 1'b1;
                state_q <= S_IDLE;
              end
            end
          endcase
        end
        S_FILL: begin
          afifo_wdata_q <= `DAP_FILL_VAL; // RQ8
          idx_q <= idx_q + 8'h01;
          if (idx_q == 8'h00) begin
            afifo_flush_q <= 1'b1;
          end else begin
            aout_push_q <= 1'b1; // RQ8
            ain_push_q <= (idx_q <= `DAP_FILL_IN); // RQ8
          end
          if (idx_q == `DAP_FILL_OUT) begin
            msg_ready_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_MEAS: begin
          if (iq_valid) begin
            acc_i_q <= sum_i;
            acc_q_q <= sum_q;
            idx_q <= idx_q + 8'h01;
            if (idx_q == `DAP_MEAS_LAST) begin
              // Mean over the window becomes the subtracted offset
              i_offset_q <= sum_i[`DAP_MEAS_LOG2 + 15:`DAP_MEAS_LOG2]; // RQ10
              q_offset_q <= sum_q[`DAP_MEAS_LOG2 + 15:`DAP_MEAS_LOG2]; // RQ10
              msg_ready_q <= 1'b1;
              state_q <= S_IDLE;
            end
          end
        end
        S_COPY: begin
          if (!started_q) begin
            if (ain_cnt16 >= words_q) begin
              started_q <= 1'b1; // RQ12
            end else if (tick_q == STEP_CYC - 16'h0001) begin
              tick_q <= 16'h0000;
              steps_q <= steps_q + 16'h0001;
              if (steps_q + 16'h0001 >= limit_q) begin
                err_valid_q <= 1'b1; // RQ13
                err_code_q <= `DAP_ERR_AIN_TIMEOUT;
                msg_ready_q <= 1'b1;
                state_q <= S_IDLE;
              end
            end else begin
              tick_q <= tick_q + 16'h0001; // RQ12
            end
          end else if (words_q == 16'h0000) begin
            msg_ready_q <= 1'b1;
            state_q <= S_IDLE;
          end else if (phase_q == 2'h0) begin
            // Head word is visible; pop it and give the FIFO a cycle to advance
            ain_pop_q <= 1'b1; // RQ11
            mem_wr_q <= 1'b1;
            mem_addr_q <= dst_q;
            mem_wdata_q <= ain_data;
            dst_q <= dst_q + 16'h0001;
            words_q <= words_q - 16'h0001;
            phase_q <= 2'h1;
          end else begin
            phase_q <= 2'h0;
          end
        end
        default: begin
          msg_ready_q <= 1'b1;
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // dap_cmd

// ---- verification/dap_cmd_sva.sv ----
`timescale 1ns/1ps
module dap_cmd_sva (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Observed ports
  input wire err_valid_q,
  input wire [7:0] err_code_q,
  input wire reset_req_q,
  input wire vlink_irq_en_q,
  input wire mem_rd_q,
  input wire mem_wr_q,
  input wire [15:0] mem_wdata_q,
  input wire [15:0] mem_rdata,
  input wire ain_pop_q,
  input wire afifo_flush_q,
  input wire ain_push_q,
  input wire aout_push_q,
  input wire [15:0] afifo_wdata_q,
  input wire iq_valid,
  input wire [15:0] i_in,
  input wire [15:0] i_offset_q,
  input wire iq_out_valid_q,
  input wire [15:0] i_out_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  chk_conv_hard_bit: assert property (mem_rd_q |-> ##2
    (mem_wr_q && mem_wdata_q == {15'h0000, $past(mem_rdata[15])})) else $error("bad hard bit");
  chk_qreset_link_off: assert property (reset_req_q |-> !vlink_irq_en_q)
    else $error("link still on at queued reset");
  chk_on_prefill_seq: assert property ($rose(vlink_irq_en_q) |=> afifo_flush_q ##1
    (ain_push_q && aout_push_q)) else $error("bad prefill start");
  chk_prefill_value: assert property ((ain_push_q || aout_push_q) |->
    afifo_wdata_q == 16'hFFFD) else $error("bad prefill value");
  chk_single_in_push: assert property (ain_push_q |=> !ain_push_q [*8])
    else $error("extra input prefill");
  chk_err_code: assert property (err_valid_q |-> err_code_q == 8'h01)
    else $error("bad error code");
  chk_pop_writes: assert property (ain_pop_q |-> mem_wr_q)
    else $error("pop without write");
  chk_iq_offset_sub: assert property (iq_valid |=> iq_out_valid_q &&
    i_out_q == $past(i_in) - $past(i_offset_q)) else $error("bad offset subtraction");
endmodule // dap_cmd_sva

// ---- verification/dap_mem_model.sv ----
`timescale 1ns/1ps
module dap_mem_model (
  // Clock
  input wire sys_clk,
  // Memory port
  input wire [15:0] addr,
  input wire rd,
  input wire wr,
  input wire [15:0] wdata,
  output reg [15:0] rdata
);
  reg [15:0] mem [0:65535];
  initial rdata = 16'h0000;
  // Read data one cycle after the strobe, otherwise a changing pattern
  always @(posedge sys_clk) begin
    if (wr) mem[addr] <= wdata;
    rdata <= rd ? mem[addr] : ~rdata;
  end
endmodule // dap_mem_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`include "dap_defs.vh"
module tb_top;
  reg sys_clk = 1'b0;
  reg srst = 1'b1;
  reg msg_valid = 1'b0;
  reg [7:0] msg_id = 8'h00;
  reg [15:0] msg_p0 = 16'h0000;
  reg [15:0] msg_p1 = 16'h0000;
  reg [15:0] msg_p2 = 16'h0000;
  reg [8:0] ain_count = 9'h000;
  reg [15:0] ain_data = 16'h0000;
  reg iq_valid = 1'b0;
  reg [15:0] i_in = 16'h0000;
  reg [15:0] q_in = 16'h0000;
  wire msg_ready_q, err_valid_q, reset_req_q, vlink_irq_en_q, mem_rd_q, mem_wr_q;
  wire ain_pop_q, afifo_flush_q, ain_push_q, aout_push_q, iq_out_valid_q;
  wire [7:0] err_code_q, reset_kind_q;
  wire [15:0] mem_addr_q, mem_wdata_q, mem_rdata, afifo_wdata_q;
  wire [15:0] i_out_q, q_out_q, i_offset_q, q_offset_q;
  integer err_count = 0;
  integer total_checks = 0;
  integer k;
  integer err_seen = 0;
  integer aout_seen = 0;
  integer ain_seen = 0;
  integer rst_seen = 0;
  reg [15:0] cyc = 16'h0000;
  reg [15:0] err_cyc = 16'h0000;
  reg [15:0] t0 = 16'h0000;
  reg [16:0] tab [0:8];
  always #50 sys_clk = ~sys_clk;
  dap_cmd dut_u (.sys_clk(sys_clk), .srst(srst), .msg_valid(msg_valid), .msg_id(msg_id),
    .msg_p0(msg_p0), .msg_p1(msg_p1), .msg_p2(msg_p2), .msg_ready_q(msg_ready_q),
    .err_valid_q(err_valid_q), .err_code_q(err_code_q), .reset_req_q(reset_req_q),
    .reset_kind_q(reset_kind_q), .vlink_irq_en_q(vlink_irq_en_q), .mem_addr_q(mem_addr_q),
    .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q), .mem_wdata_q(mem_wdata_q),
    .mem_rdata(mem_rdata), .ain_count(ain_count), .ain_data(ain_data), .ain_pop_q(ain_pop_q),
    .afifo_flush_q(afifo_flush_q), .ain_push_q(ain_push_q), .aout_push_q(aout_push_q),
    .afifo_wdata_q(afifo_wdata_q), .iq_valid(iq_valid), .i_in(i_in), .q_in(q_in),
    .iq_out_valid_q(iq_out_valid_q), .i_out_q(i_out_q), .q_out_q(q_out_q),
    .i_offset_q(i_offset_q), .q_offset_q(q_offset_q));
  dap_mem_model mem_u (.sys_clk(sys_clk), .addr(mem_addr_q), .rd(mem_rd_q), .wr(mem_wr_q),
    .wdata(mem_wdata_q), .rdata(mem_rdata));
  // Pulse counters; the error edge is latched one edge after it is driven
  always @(posedge sys_clk) begin
    cyc <= cyc + 16'h0001;
    if (err_valid_q === 1'b1) begin
      err_seen <= err_seen + 1;
      err_cyc <= cyc;
    end
    if (aout_push_q === 1'b1) aout_seen <= aout_seen + 1;
    if (ain_push_q === 1'b1) ain_seen <= ain_seen + 1;
    if (reset_req_q === 1'b1) rst_seen <= rst_seen + 1;
  end
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task tick;
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task wait_ready;
    integer w;
    begin
      w = 0;
      while (msg_ready_q !== 1'b1 && w < 4000) begin
        tick;
        w = w + 1;
      end
      if (msg_ready_q !== 1'b1) begin
        err_count = err_count + 1;
        stop_test;
      end
    end
  endtask
  // Offer one message, hold it until taken, then wait for completion
  task send(input [7:0] id, input [15:0] a, input [15:0] b, input [15:0] c);
    begin
      msg_id = id;
      msg_p0 = a;
      msg_p1 = b;
      msg_p2 = c;
      msg_valid = 1'b1;
      wait_ready;
      tick;
      msg_valid = 1'b0;
      tick;
      tick;
      wait_ready;
      // Let the last memory write and pulse counters settle
      tick;
    end
  endtask
  initial begin
    tab[0] = {`DAP_ID_LINK_ON, 8'h00, 1'b1};
    tab[1] = {`DAP_ID_LINK_OFF, 8'h00, 1'b0};
    tab[2] = {`DAP_ID_LINK_ON, 8'h00, 1'b1};
    tab[3] = {`DAP_ID_QRESET, 8'h05, 1'b0};
    tab[4] = {`DAP_ID_COND_FILL, 8'h10, 1'b0};
    tab[5] = {`DAP_ID_LINK_ON, 8'h00, 1'b0};
    tab[6] = {`DAP_ID_COND_FILL, 8'h00, 1'b0};
    tab[7] = {`DAP_ID_LINK_ON, 8'h00, 1'b1};
    tab[8] = {8'h00, 8'h00, 1'b1};
    for (k = 0; k < 256; k = k + 1) begin
      mem_u.mem[16'h0100 + k] = k[0] ? 16'h0005 : 16'h8001;
      mem_u.mem[16'h0200 + k] = 16'hAAAA;
    end
    mem_u.mem[16'h0400] = 16'h5555;
    repeat (5) @(posedge sys_clk);
    #1 srst = 1'b0;
    chk({15'h0000, msg_ready_q}, 16'h0001);
    chk({15'h0000, vlink_irq_en_q}, 16'h0000);
    for (k = 0; k < 9; k = k + 1) begin
      send(tab[k][16:9], {8'h00, tab[k][8:1]}, 16'h0001, 16'h0000);
      chk({15'h0000, vlink_irq_en_q}, {15'h0000, tab[k][0]});
    end
    chk({8'h00, reset_kind_q}, 16'h0005);
    // Four link-on commands were sent, the third was skipped
    chk(aout_seen[15:0], 16'h01BC);
    chk(ain_seen[15:0], 16'h0003);
    chk(rst_seen[15:0], 16'h0001);
    $display("message table done");
    send(`DAP_ID_CONVERT, 16'h0001, 16'h0002, 16'h0000);
    for (k = 0; k < 114; k = k + 1) chk(mem_u.mem[16'h0200 + k], {15'h0000, ~k[0]});
    chk(mem_u.mem[16'h0272], 16'hAAAA);
    $display("convert done");
    t0 = cyc;
    send(`DAP_ID_AIN_COPY, 16'h0004, 16'h0003, 16'h0001);
    chk(err_seen[15:0], 16'h0001);
    chk({8'h00, err_code_q}, {8'h00, `DAP_ERR_AIN_TIMEOUT});
    chk(err_cyc - t0, `DAP_STEP_CYC + 16'h0001);
    chk(mem_u.mem[16'h0400], 16'h5555);
    ain_count = 9'h003;
    ain_data = 16'h1234;
    send(`DAP_ID_AIN_COPY, 16'h0003, 16'h0002, 16'h0005);
    chk(mem_u.mem[16'h0300], 16'h1234);
    chk(mem_u.mem[16'h0301], 16'h1234);
    chk(err_seen[15:0], 16'h0001);
    $display("audio copy done");
    i_in = 16'h0008;
    q_in = 16'hFFFC;
    iq_valid = 1'b1;
    send(`DAP_ID_IQ_COMP, 16'h0000, 16'h0000, 16'h0000);
    chk(i_offset_q, 16'h0008);
    chk(q_offset_q, 16'hFFFC);
    i_in = 16'h0010;
    q_in = 16'h0000;
    tick;
    chk(i_out_q, 16'h0008);
    chk(q_out_q, 16'h0004);
    chk({15'h0000, iq_out_valid_q}, 16'h0001);
    iq_valid = 1'b0;
    $display("offset done");
    srst = 1'b1;
    tick;
    srst = 1'b0;
    chk({15'h0000, vlink_irq_en_q}, 16'h0000);
    chk({15'h0000, msg_ready_q}, 16'h0001);
    send(`DAP_ID_LINK_ON, 16'h0000, 16'h0000, 16'h0000);
    chk({15'h0000, vlink_irq_en_q}, 16'h0001);
    $display("reset done");
    stop_test;
  end
endmodule // tb_top
bind dap_cmd dap_cmd_sva chk_u (.sys_clk(sys_clk), .srst(srst), .err_valid_q(err_valid_q),
  .err_code_q(err_code_q), .reset_req_q(reset_req_q), .vlink_irq_en_q(vlink_irq_en_q),
  .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q), .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata),
  .ain_pop_q(ain_pop_q), .afifo_flush_q(afifo_flush_q), .ain_push_q(ain_push_q),
  .aout_push_q(aout_push_q), .afifo_wdata_q(afifo_wdata_q), .iq_valid(iq_valid),
  .i_in(i_in), .i_offset_q(i_offset_q), .iq_out_valid_q(iq_out_valid_q), .i_out_q(i_out_q));
